/* File: common/itfd_defines.vh */
// Purpose: Constants for the input terminal function dispatch block.
// Assumes: 25 MHz system clock, 32-bit APB register access.
// Notes: Filter time is held in milliseconds; a millisecond tick comes from a divider.
`ifndef ITFD_DEFINES_VH
`define ITFD_DEFINES_VH

`define ITFD_NUM_TERM 5
`define ITFD_CLK_HZ 25000000
`define ITFD_TICK_MS 1000
`define ITFD_MS_CYCLES (`ITFD_CLK_HZ / `ITFD_TICK_MS)
`define ITFD_MS_CNT_W 15
`define ITFD_FILT_W 11
`define ITFD_FILT_MAX 11'h03E8
`define ITFD_FILT_RST 11'h000A

`define ITFD_FN_PID_REV 6'h23
`define ITFD_FN_STOP1 6'h24
`define ITFD_FN_CMD_SW2 6'h25
`define ITFD_FN_INT_HOLD 6'h26
`define ITFD_FN_SRCX_KEY 6'h27
`define ITFD_FN_SRCY_KEY 6'h28
`define ITFD_FN_RSV41 6'h29
`define ITFD_FN_RSV42 6'h2A
`define ITFD_FN_GAIN_SW 6'h2B
`define ITFD_FN_RSV44 6'h2C
`define ITFD_FN_RSV45 6'h2D
`define ITFD_FN_SPD_TRQ 6'h2E
`define ITFD_FN_ESTOP 6'h2F
`define ITFD_FN_STOP2 6'h30
`define ITFD_FN_DEC_DCB 6'h31
`define ITFD_FN_CLR_TIME 6'h32

`define ITFD_SRC_KEYPAD 2'h0
`define ITFD_DECEL_SET4 2'h3

`define ITFD_ADDR_FUNC0 12'h000
`define ITFD_ADDR_FUNC1 12'h004
`define ITFD_ADDR_FILT 12'h008
`define ITFD_ADDR_CFG 12'h00C
`define ITFD_ADDR_STAT 12'h010
`define ITFD_ADDR_REQ 12'h014

`define ITFD_FUNC_W 6
`define ITFD_FUNC0_TERMS 4
`define ITFD_FUNC_LANE 8
`define ITFD_REQ_W 15
`define ITFD_CFG_PIDDIR 0
`define ITFD_CFG_SRC_LO 1
`define ITFD_CFG_SRC_HI 2
`define ITFD_CFG_GAINSEL 3
`define ITFD_CFG_TRQMODE 4
`define ITFD_CFG_W 5

`endif

/* File: design/itfd_ms_tick.v */
// Purpose: Divides the system clock into a one-cycle millisecond enable.
// Assumes: ITFD_MS_CYCLES fits in ITFD_MS_CNT_W bits.
// Notes: Free running from reset.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module itfd_ms_tick (
   input wire CLOCK_I,
   input wire RST_B_I,
   output reg tick_o
);
   localparam integer LAST_I = `ITFD_MS_CYCLES - 1;
   localparam [`ITFD_MS_CNT_W-1:0] LAST = LAST_I[`ITFD_MS_CNT_W-1:0];
   reg [`ITFD_MS_CNT_W-1:0] cnt_r;

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cnt_r <= {`ITFD_MS_CNT_W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_r == LAST);
         if (cnt_r == LAST) begin
            cnt_r <= {`ITFD_MS_CNT_W{1'b0}};
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

/* File: design/itfd_debounce.v */
// Purpose: Synchronises one terminal and accepts a new level only after it is stable.
// Assumes: tick_i is a one-cycle pulse each millisecond.
// Notes: A filter time of zero passes the synchronised level straight through.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module itfd_debounce (
   input wire CLOCK_I,
   input wire RST_B_I,
   input wire pin_i,
   input wire tick_i,
   input wire [`ITFD_FILT_W-1:0] filt_ms_i,
   output reg level_o
);
   reg sync1_r;
   reg sync2_r;
   reg [`ITFD_FILT_W-1:0] cnt_r;

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         cnt_r <= {`ITFD_FILT_W{1'b0}};
         level_o <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         // [R14] Stability timer restarts on any bounce.
         if (sync2_r == level_o) begin
            cnt_r <= {`ITFD_FILT_W{1'b0}};
         // The tick runs free, so the first tick may come at once; one extra tick
         // guarantees that a level is held for at least the whole filter time.
         end else if ((filt_ms_i == {`ITFD_FILT_W{1'b0}}) || (cnt_r > filt_ms_i)) begin
            level_o <= sync2_r;
            cnt_r <= {`ITFD_FILT_W{1'b0}};
         end else if (tick_i) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

/* File: design/itfd_top.v */
// Purpose: Maps filtered input terminals with function codes 35 to 50 onto control requests.
// Assumes: APB slave, 25 MHz clock, five terminals, one function code per terminal.
// Notes: Requests are levels held while the terminal stays valid; the core decides timing.
// Operation
// [R1] Function 35 inverts configured regulator direction.
// [R2] Function 36 stops only under keypad control.
// [R3] Function 37 picks terminal or communication commands.
// [R4] Function 38 freezes the integral term only.
// [R5] Function 39 puts keypad frequency on X.
// [R6] Function 40 puts keypad frequency on Y.
// [R7] Function 43 selects gain set when enabled.
// [R8] Function 46 flips configured speed/torque mode.
// [R9] Function 47 fastest stop at current limit.
// [R10] Function 48 stops using fourth deceleration time.
// [R11] Function 49 decelerates then DC braking.
// [R12] Function 50 clears the run time counter.
// [R13] Codes 41, 42, 44, 45 do nothing.
// [R14] Every terminal passes a configurable debounce filter.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module itfd_top (
   input wire CLOCK_I,
   input wire RST_B_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output wire PREADY_O,
   output wire PSLVERR_O,
   input wire [`ITFD_NUM_TERM-1:0] MULTI_FUNCTION_INPUT_I,
   output reg REG_DIR_REVERSE_O,
   output reg KEYPAD_STOP_REQ_O,
   output reg CMD_SRC_COMM_O,
   output reg INTEGRAL_HOLD_O,
   output reg SRC_X_KEYPAD_O,
   output reg SRC_Y_KEYPAD_O,
   output reg GAIN_SET2_O,
   output reg TORQUE_MODE_O,
   output reg EMERGENCY_STOP_O,
   output reg CURRENT_LIMIT_STOP_O,
   output reg DECEL_STOP_REQ_O,
   output reg [1:0] DECEL_TIME_SEL_O,
   output reg DC_BRAKE_DECEL_O,
   output reg RUN_TIME_CLEAR_O
);
   localparam NT = `ITFD_NUM_TERM;
   localparam FW = `ITFD_FUNC_W;

   reg [FW*NT-1:0] func_r;
   reg [`ITFD_FILT_W-1:0] filt_r;
   reg [`ITFD_CFG_W-1:0] cfg_r;
   wire [NT-1:0] level;
   wire tick;
   wire wr_en;
   wire rd_en;
   wire addr_ok;
   reg [NT-1:0] hit_35, hit_36, hit_37, hit_38, hit_39, hit_40, hit_43;
   reg [NT-1:0] hit_46, hit_47, hit_48, hit_49, hit_50;
   reg [31:0] rd_nxt;
   integer k;
   integer m;
   integer j;

   itfd_ms_tick u_tick (
      .CLOCK_I(CLOCK_I),
      .RST_B_I(RST_B_I),
      .tick_o(tick)
   );

   genvar g;
   generate
      for (g = 0; g < NT; g = g + 1) begin : g_term
         // [R14] Filter per terminal.
         itfd_debounce u_deb (
            .CLOCK_I(CLOCK_I),
            .RST_B_I(RST_B_I),
            .pin_i(MULTI_FUNCTION_INPUT_I[g]),
            .tick_i(tick),
            .filt_ms_i(filt_r),
            .level_o(level[g])
         );
      end
   endgenerate

   // Every access completes in its first access cycle, so the slave never waits.
   assign PREADY_O = 1'b1;
   assign addr_ok = (PADDR_I == `ITFD_ADDR_FUNC0) || (PADDR_I == `ITFD_ADDR_FUNC1) ||
                    (PADDR_I == `ITFD_ADDR_FILT) || (PADDR_I == `ITFD_ADDR_CFG) ||
                    (PADDR_I == `ITFD_ADDR_STAT) || (PADDR_I == `ITFD_ADDR_REQ);
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & addr_ok;
   assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         func_r <= {FW*NT{1'b0}};
         filt_r <= `ITFD_FILT_RST;
         cfg_r <= {`ITFD_CFG_W{1'b0}};
      end else if (wr_en) begin
         case (PADDR_I)
            `ITFD_ADDR_FUNC0: begin
               for (m = 0; m < `ITFD_FUNC0_TERMS; m = m + 1) begin
                  func_r[FW*m +: FW] <= PWDATA_I[`ITFD_FUNC_LANE*m +: FW];
               end
            end
            `ITFD_ADDR_FUNC1: func_r[FW*`ITFD_FUNC0_TERMS +: FW] <= PWDATA_I[FW-1:0];
            `ITFD_ADDR_FILT: begin
               // Values above one second are clamped rather than refused.
               if (PWDATA_I[`ITFD_FILT_W-1:0] > `ITFD_FILT_MAX || (|PWDATA_I[31:`ITFD_FILT_W])) begin
                  filt_r <= `ITFD_FILT_MAX;
               end else begin
                  filt_r <= PWDATA_I[`ITFD_FILT_W-1:0];
               end
            end
            `ITFD_ADDR_CFG: cfg_r <= PWDATA_I[`ITFD_CFG_W-1:0];
            default: cfg_r <= cfg_r;
         endcase
      end
   end

   always @* begin
      rd_nxt = 32'h0000_0000;
      case (PADDR_I)
         `ITFD_ADDR_FUNC0: begin
            for (j = 0; j < `ITFD_FUNC0_TERMS; j = j + 1) begin
               rd_nxt[`ITFD_FUNC_LANE*j +: FW] = func_r[FW*j +: FW];
            end
         end
         `ITFD_ADDR_FUNC1: rd_nxt[FW-1:0] = func_r[FW*`ITFD_FUNC0_TERMS +: FW];
         `ITFD_ADDR_FILT: rd_nxt[`ITFD_FILT_W-1:0] = filt_r;
         `ITFD_ADDR_CFG: rd_nxt[`ITFD_CFG_W-1:0] = cfg_r;
         `ITFD_ADDR_STAT: rd_nxt[NT-1:0] = level;
         `ITFD_ADDR_REQ: rd_nxt[`ITFD_REQ_W-1:0] = {RUN_TIME_CLEAR_O, DC_BRAKE_DECEL_O, DECEL_TIME_SEL_O, DECEL_STOP_REQ_O,
                                   CURRENT_LIMIT_STOP_O, EMERGENCY_STOP_O, TORQUE_MODE_O, GAIN_SET2_O,
                                   SRC_Y_KEYPAD_O, SRC_X_KEYPAD_O, INTEGRAL_HOLD_O, CMD_SRC_COMM_O,
                                   KEYPAD_STOP_REQ_O, REG_DIR_REVERSE_O};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
         PRDATA_O <= rd_nxt;
      end else if (rd_en) begin
         PRDATA_O <= PRDATA_O;
      end
   end

   // Per-terminal match of valid level against its assigned code.
   always @* begin
      for (k = 0; k < NT; k = k + 1) begin
         hit_35[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_PID_REV);
         hit_36[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_STOP1);
         hit_37[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_CMD_SW2);
         hit_38[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_INT_HOLD);
         hit_39[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_SRCX_KEY);
         hit_40[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_SRCY_KEY);
         hit_43[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_GAIN_SW);
         hit_46[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_SPD_TRQ);
         hit_47[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_ESTOP);
         hit_48[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_STOP2);
         hit_49[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_DEC_DCB);
         hit_50[k] = level[k] && (func_r[FW*k +: FW] == `ITFD_FN_CLR_TIME);
      end
   end

   // [R13] Reserved codes 41, 42, 44, 45 have no decoder, so they drive nothing.
   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG_DIR_REVERSE_O <= 1'b0;
         KEYPAD_STOP_REQ_O <= 1'b0;
         CMD_SRC_COMM_O <= 1'b0;
         INTEGRAL_HOLD_O <= 1'b0;
         SRC_X_KEYPAD_O <= 1'b0;
         SRC_Y_KEYPAD_O <= 1'b0;
         GAIN_SET2_O <= 1'b0;
         TORQUE_MODE_O <= 1'b0;
         EMERGENCY_STOP_O <= 1'b0;
         CURRENT_LIMIT_STOP_O <= 1'b0;
         DECEL_STOP_REQ_O <= 1'b0;
         DECEL_TIME_SEL_O <= 2'h0;
         DC_BRAKE_DECEL_O <= 1'b0;
         RUN_TIME_CLEAR_O <= 1'b0;
      end else begin
         // [R1] Direction inversion.
         REG_DIR_REVERSE_O <= cfg_r[`ITFD_CFG_PIDDIR] ^ (|hit_35);
         // [R2] Keypad-only stop.
         KEYPAD_STOP_REQ_O <= (|hit_36) && (cfg_r[`ITFD_CFG_SRC_HI:`ITFD_CFG_SRC_LO] == `ITFD_SRC_KEYPAD);
         // [R3] Source select, valid means communication.
         CMD_SRC_COMM_O <= |hit_37;
         // [R4] Integral freeze only.
         INTEGRAL_HOLD_O <= |hit_38;
         // [R5] Keypad replaces X.
         SRC_X_KEYPAD_O <= |hit_39;
         // [R6] Keypad replaces Y.
         SRC_Y_KEYPAD_O <= |hit_40;
         // [R7] Gain set select.
         GAIN_SET2_O <= cfg_r[`ITFD_CFG_GAINSEL] & (|hit_43);
         // [R8] Mode flip.
         TORQUE_MODE_O <= cfg_r[`ITFD_CFG_TRQMODE] ^ (|hit_46);
         // [R9] Fastest stop at limit.
         EMERGENCY_STOP_O <= |hit_47;
         CURRENT_LIMIT_STOP_O <= |hit_47;
         // [R10] Stop with fourth decel time.
         DECEL_STOP_REQ_O <= |hit_48;
         DECEL_TIME_SEL_O <= (|hit_48) ? `ITFD_DECEL_SET4 : 2'h0;
         // [R11] Decel then DC braking.
         DC_BRAKE_DECEL_O <= |hit_49;
         // [R12] Run timer clear.
         RUN_TIME_CLEAR_O <= |hit_50;
      end
   end
endmodule

/* File: tb/itfd_contacts.sv */
// Purpose: Switch contacts that drive the five input terminals.
// Assumes: Contacts change only just after a clock edge.
// Notes: Closing is prompt; the block under test does all filtering.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module itfd_contacts (
   input wire CLOCK_I,
   input wire [`ITFD_NUM_TERM-1:0] close_i,
   output reg [`ITFD_NUM_TERM-1:0] pins_o
);
   initial pins_o = 5'h00;
   always @(posedge CLOCK_I) begin
      pins_o <= close_i;
   end
endmodule

/* File: tb/itfd_checker_assertions.sv */
// Purpose: Port checks for the terminal dispatch block.
// Assumes: Requests rise only after a bus write or a valid terminal.
// Notes: Bound onto itfd_top.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module itfd_checker (
   input wire CLOCK_I,
   input wire RST_B_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PRDATA_O,
   input wire PREADY_O,
   input wire PSLVERR_O,
   input wire [`ITFD_NUM_TERM-1:0] MULTI_FUNCTION_INPUT_I,
   input wire EMERGENCY_STOP_O,
   input wire CURRENT_LIMIT_STOP_O,
   input wire DECEL_STOP_REQ_O,
   input wire [1:0] DECEL_TIME_SEL_O,
   input wire DC_BRAKE_DECEL_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   a_stop_pair_match: assert property (EMERGENCY_STOP_O == CURRENT_LIMIT_STOP_O)
      else $error("emergency stop and current limit stop differ");
   a_decel_set_four: assert property (DECEL_TIME_SEL_O == (DECEL_STOP_REQ_O ? 2'h3 : 2'h0))
      else $error("deceleration set does not follow stop request");
   a_ready_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
      else $error("access phase without ready");
   a_err_access_only: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
      else $error("error outside access phase");
   a_err_mapped_none: assert property (PSEL_I && PENABLE_I && PADDR_I <= 12'h014 && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
      else $error("error on a mapped address");
   a_err_read_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0000_0000)
      else $error("refused read returned data");
   a_estop_needs_pin: assert property ($rose(EMERGENCY_STOP_O) && !$past(PSEL_I) |->
      $past(|MULTI_FUNCTION_INPUT_I, 3))
      else $error("emergency stop rose without a terminal");
   a_brake_needs_pin: assert property ($rose(DC_BRAKE_DECEL_O) && !$past(PSEL_I) |->
      $past(|MULTI_FUNCTION_INPUT_I, 3))
      else $error("braking rose without a terminal");
endmodule
bind itfd_top itfd_checker u_chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .MULTI_FUNCTION_INPUT_I(MULTI_FUNCTION_INPUT_I), .EMERGENCY_STOP_O(EMERGENCY_STOP_O),
   .CURRENT_LIMIT_STOP_O(CURRENT_LIMIT_STOP_O), .DECEL_STOP_REQ_O(DECEL_STOP_REQ_O),
   .DECEL_TIME_SEL_O(DECEL_TIME_SEL_O), .DC_BRAKE_DECEL_O(DC_BRAKE_DECEL_O));

/* File: tb/testbench.sv */
// Purpose: Register and terminal tests for the dispatch block.
// Assumes: Zero wait bus answers may still come late; waits are bounded.
// Notes: Filter zero keeps the code table fast; one test runs at 1 ms.
`timescale 1ns/10ps
`include "itfd_defines.vh"
module testbench;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000;
   reg [4:0] close = 5'h00;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [4:0] pins;
   wire [14:0] req;
   integer bad_count = 0, n_checks = 0, ci, c, v;
   reg [31:0] q;
   reg e;
   reg [4:0] cfgs [0:2];
   always #20 clk = ~clk;
   itfd_contacts u_sw (.CLOCK_I(clk), .close_i(close), .pins_o(pins));
   itfd_top u_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .MULTI_FUNCTION_INPUT_I(pins), .REG_DIR_REVERSE_O(req[0]), .KEYPAD_STOP_REQ_O(req[1]),
      .CMD_SRC_COMM_O(req[2]), .INTEGRAL_HOLD_O(req[3]), .SRC_X_KEYPAD_O(req[4]), .SRC_Y_KEYPAD_O(req[5]),
      .GAIN_SET2_O(req[6]), .TORQUE_MODE_O(req[7]), .EMERGENCY_STOP_O(req[8]), .CURRENT_LIMIT_STOP_O(req[9]),
      .DECEL_STOP_REQ_O(req[10]), .DECEL_TIME_SEL_O(req[12:11]), .DC_BRAKE_DECEL_O(req[13]),
      .RUN_TIME_CLEAR_O(req[14]));
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== ex) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 100);
         if (pready !== 1'b1) begin
            bad_count = bad_count + 1;
            tally_and_finish;
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rdc(input string nm, input [11:0] a, input [31:0] ex);
      begin
         apb(1'b0, a, 32'h0000_0000);
         chk(nm, ex, q);
      end
   endtask
   function [14:0] exp_req(input [5:0] k, input [4:0] g, input s);
      reg [14:0] r;
      begin
         r = 15'h0000;
         r[0] = g[0] ^ (s && k == `ITFD_FN_PID_REV);
         r[1] = s && k == `ITFD_FN_STOP1 && g[2:1] == `ITFD_SRC_KEYPAD;
         r[2] = s && k == `ITFD_FN_CMD_SW2;
         r[3] = s && k == `ITFD_FN_INT_HOLD;
         r[4] = s && k == `ITFD_FN_SRCX_KEY;
         r[5] = s && k == `ITFD_FN_SRCY_KEY;
         r[6] = g[3] && s && k == `ITFD_FN_GAIN_SW;
         r[7] = g[4] ^ (s && k == `ITFD_FN_SPD_TRQ);
         r[9:8] = {2{s && k == `ITFD_FN_ESTOP}};
         r[12:10] = {3{s && k == `ITFD_FN_STOP2}};
         r[13] = s && k == `ITFD_FN_DEC_DCB;
         r[14] = s && k == `ITFD_FN_CLR_TIME;
         exp_req = r;
      end
   endfunction
   initial begin
      cfgs[0] = 5'h00;
      cfgs[1] = 5'h19;
      cfgs[2] = 5'h1E;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc("filter reset", `ITFD_ADDR_FILT, 32'h0000_000A);
      apb(1'b1, `ITFD_ADDR_FILT, 32'h0000_07D0);
      rdc("filter clamp", `ITFD_ADDR_FILT, 32'h0000_03E8);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
      chk("unmapped data", 32'h0000_0000, q);
      $display("test registers done");
      apb(1'b1, `ITFD_ADDR_FILT, 32'h0000_0001);
      apb(1'b1, `ITFD_ADDR_FUNC0, {4{2'h0, `ITFD_FN_ESTOP}});
      close <= 5'h01;
      repeat (500) @(posedge clk);
      close <= 5'h00;
      rdc("bounce ignored", `ITFD_ADDR_STAT, 32'h0000_0000);
      close <= 5'h01;
      repeat (24000) @(posedge clk);
      rdc("before filter time", `ITFD_ADDR_STAT, 32'h0000_0000);
      repeat (27000) @(posedge clk);
      rdc("after filter time", `ITFD_ADDR_STAT, 32'h0000_0001);
      chk("stop after filter", 32'h0000_0300, {17'h0_0000, req & 15'h0300});
      close <= 5'h00;
      apb(1'b1, `ITFD_ADDR_FILT, 32'h0000_0000);
      $display("test debounce done");
      for (ci = 0; ci < 3; ci = ci + 1) begin
         apb(1'b1, `ITFD_ADDR_CFG, {27'h000_0000, cfgs[ci]});
         for (c = 35; c <= 50; c = c + 1) begin
            apb(1'b1, `ITFD_ADDR_FUNC0, {4{2'h0, c[5:0]}});
            apb(1'b1, `ITFD_ADDR_FUNC1, {26'h000_0000, c[5:0]});
            for (v = 0; v < 2; v = v + 1) begin
               close <= (v == 1) ? (5'h01 << (c % 5)) : 5'h00;
               repeat (10) @(posedge clk);
               chk("request ports", {17'h0_0000, exp_req(c[5:0], cfgs[ci], v[0])}, {17'h0_0000, req});
               rdc("request snapshot", `ITFD_ADDR_REQ, {17'h0_0000, exp_req(c[5:0], cfgs[ci], v[0])});
            end
         end
         $display("test code table done");
      end
      close <= 5'h00;
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("requests after reset", 32'h0000_0000, {17'h0_0000, req});
      rdc("filter after reset", `ITFD_ADDR_FILT, 32'h0000_000A);
      rdc("config after reset", `ITFD_ADDR_CFG, 32'h0000_0000);
      rdc("snapshot after reset", `ITFD_ADDR_REQ, 32'h0000_0000);
      $display("test reset done");
      tally_and_finish;
   end
endmodule
